//--- flash_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport host
    (
        output sck,
        output cs_n,
        output mosi,
        input  miso,
        input  miso_oe
    );

    modport device
    (
        input  sck,
        input  cs_n,
        input  mosi,
        output miso,
        output miso_oe
    );
endinterface
`default_nettype wire

//--- flash_susp_checker_placeholder.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- flash_susp_device.sv
`timescale 1ns/1ps
`default_nettype none
module flash_susp_device
    import flash_susp_pkg::*;
#(
    parameter int ERASE_CYCLES         = ERASE_WORK_CYCLES,
    parameter int PROGRAM_CYCLES       = PROGRAM_WORK_CYCLES,
    parameter int ERASE_SUSPEND_CYCLES = ERASE_SUSP_MAX_CYCLES,
    parameter int PROG_SUSPEND_CYCLES  = PROGRAM_SUSP_MAX_CYCLES
)
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire logic     start_erase,
    input  wire logic     start_program,
    output logic          busy_in_progress_flag,
    output logic          erase_suspended,
    output logic          program_suspended,
    output logic          op_done,
    flash_link_if.device  lnk
);
    wire link_rst = rst | lnk.cs_n;

    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] cmd_hold;
    logic       cmd_tgl;
    logic       send;
    logic [2:0] out_idx;
    logic [7:0] out_byte;
    logic       b1;
    logic       b2;
    logic       b3;
    logic       busy_seen;
    logic       miso_q;

    wire [7:0] rx_byte   = {rx_sh[6:0], lnk.mosi};
    wire       byte_done = (bit_cnt == 3'h7) && !send;

    // Frame logic is reset by chip select so nothing depends on a clock edge outside the frame.
    always_ff @(posedge lnk.sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            bit_cnt <= 3'h0;
            rx_sh   <= 8'h00;
        end
        else
        begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= rx_byte;
        end
    end

    // The held opcode stays stable until the next toggle, long after the clk side has read it.
    always_ff @(posedge lnk.sck or posedge rst)
    begin
        if (rst)
        begin
            cmd_hold <= 8'h00;
            cmd_tgl  <= 1'b0;
        end
        else if (byte_done && rx_byte != OP_READ_STATUS)
        begin
            cmd_hold <= rx_byte;
            cmd_tgl  <= ~cmd_tgl;
        end
    end

    always_ff @(posedge lnk.sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            send    <= 1'b0;
            out_idx <= 3'h0;
        end
        else if (byte_done && rx_byte == OP_READ_STATUS)
        begin
            send    <= 1'b1;
            out_idx <= 3'h0;
        end
        else if (send)
        begin
            out_idx <= out_idx + 3'h1;
        end
    end

    always_ff @(posedge lnk.sck or posedge rst)
    begin
        if (rst)
        begin
            b1 <= 1'b0;
            b2 <= 1'b0;
            b3 <= 1'b0;
            busy_seen <= 1'b0;
        end
        else
        begin
            b1 <= busy_in_progress_flag;
            b2 <= b1;
            b3 <= b2;
            if (b2 == b3)
            begin
                busy_seen <= b3;
            end
        end
    end

    // The status byte is refreshed once per byte so a continuous read shows a fresh flag.
    always_ff @(posedge lnk.sck or posedge rst)
    begin
        if (rst)
        begin
            out_byte <= 8'h00;
        end
        else if (byte_done || (send && out_idx == 3'h7))
        begin
            out_byte <= 8'(busy_seen) << STATUS_BUSY_BIT;
        end
    end

    always_ff @(negedge lnk.sck or posedge link_rst)
    begin
        if (link_rst)
        begin
            miso_q <= 1'b0;
        end
        else
        begin
            miso_q <= send ? out_byte[3'h7 - out_idx] : 1'b0;
        end
    end

    assign lnk.miso    = miso_q;
    assign lnk.miso_oe = send;

    logic s1;
    logic s2;
    logic s3;
    logic tgl_seen;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            tgl_seen <= 1'b0;
        end
        else
        begin
            s1 <= cmd_tgl;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
            begin
                tgl_seen <= s3;
            end
        end
    end

    wire cmd_evt = (s2 == s3) && (s3 != tgl_seen);

    dev_state_t       state;
    logic [CNT_W-1:0] erase_left;
    logic [CNT_W-1:0] prog_left;
    logic [CNT_W-1:0] stop_cnt;

    wire erase_go = (state == ST_IDLE) && start_erase && !erase_suspended && !program_suspended;
    wire prog_go  = (state == ST_IDLE) && start_program && !program_suspended && !erase_go;
    wire e_susp   = cmd_evt && cmd_hold == OP_ERASE_SUSPEND && state == ST_ERASE;
    wire p_susp   = cmd_evt && cmd_hold == OP_PROGRAM_SUSPEND && state == ST_PROG;
    wire e_res    = cmd_evt && cmd_hold == OP_ERASE_RESUME && state == ST_IDLE && erase_suspended;
    wire p_res    = cmd_evt && cmd_hold == OP_PROGRAM_RESUME && state == ST_IDLE && program_suspended;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state    <= ST_IDLE;
            stop_cnt <= '0;
            op_done  <= 1'b0;
        end
        else
        begin
            op_done <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (erase_go || e_res)
                    begin
                        state <= ST_ERASE;
                    end
                    else if (prog_go || p_res)
                    begin
                        state <= ST_PROG;
                    end
                end
                ST_ERASE:
                begin
                    if (e_susp)
                    begin
                        state    <= ST_ERASE_STOP;
                        stop_cnt <= CNT_W'(ERASE_SUSPEND_CYCLES - 1);
                    end
                    else if (erase_left == CNT_W'(1))
                    begin
                        state   <= ST_IDLE;
                        op_done <= 1'b1;
                    end
                end
                ST_PROG:
                begin
                    if (p_susp)
                    begin
                        state    <= ST_PROG_STOP;
                        stop_cnt <= CNT_W'(PROG_SUSPEND_CYCLES - 1);
                    end
                    else if (prog_left == CNT_W'(1))
                    begin
                        state   <= ST_IDLE;
                        op_done <= 1'b1;
                    end
                end
                ST_ERASE_STOP, ST_PROG_STOP:
                begin
                    if (stop_cnt == '0)
                    begin
                        state <= ST_IDLE;
                    end
                    else
                    begin
                        stop_cnt <= stop_cnt - CNT_W'(1);
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Remaining work is kept across a suspension so a resume continues where it stopped.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            erase_left <= '0;
            prog_left  <= '0;
        end
        else
        begin
            if (erase_go)
            begin
                erase_left <= CNT_W'(ERASE_CYCLES);
            end
            else if (state == ST_ERASE && !e_susp)
            begin
                erase_left <= erase_left - CNT_W'(1);
            end
            if (prog_go)
            begin
                prog_left <= CNT_W'(PROGRAM_CYCLES);
            end
            else if (state == ST_PROG && !p_susp)
            begin
                prog_left <= prog_left - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            erase_suspended   <= 1'b0;
            program_suspended <= 1'b0;
        end
        else
        begin
            if (state == ST_ERASE_STOP && stop_cnt == '0)
            begin
                erase_suspended <= 1'b1;
            end
            else if (e_res)
            begin
                erase_suspended <= 1'b0;
            end
            if (state == ST_PROG_STOP && stop_cnt == '0)
            begin
                program_suspended <= 1'b1;
            end
            else if (p_res)
            begin
                program_suspended <= 1'b0;
            end
        end
    end

    assign busy_in_progress_flag = (state != ST_IDLE);
endmodule
`default_nettype wire

//--- flash_susp_host.sv
`timescale 1ns/1ps
`default_nettype none
module flash_susp_host
    import flash_susp_pkg::*;
#(
    parameter int SCK_HALF          = SCK_HALF_CYCLES,
    parameter int ERASE_RESUME_GAP  = ERASE_RESUME_GAP_CYCLES,
    parameter int PROG_RESUME_GAP   = PROGRAM_RESUME_GAP_CYCLES,
    parameter int SECT_W            = SECTOR_W
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              cmd_valid,
    input  wire logic [7:0]        cmd_opcode,
    output logic                   cmd_ready,
    output logic                   status_valid,
    output logic [7:0]             status_byte,
    output logic                   busy_in_progress_flag,
    input  wire logic [SECT_W-1:0] erase_sector,
    input  wire logic [SECT_W-1:0] program_sector,
    output logic                   erase_held,
    output logic                   program_held,
    output logic                   erase_start_ok,
    output logic                   program_start_ok,
    flash_link_if.host             lnk
);
    host_state_t       state;
    logic [CNT_W-1:0]  half_cnt;
    logic [4:0]        edge_cnt;
    logic [4:0]        last_edge;
    logic [7:0]        op_q;
    logic [7:0]        tx;
    logic [7:0]        rx;
    logic [CNT_W-1:0]  erase_gap;
    logic [CNT_W-1:0]  prog_gap;
    logic [SECT_W-1:0] held_sector;
    logic              sck_q;
    logic              cs_n_q;
    logic              mosi_q;
    logic              m1;
    logic              m2;
    logic              m3;
    logic              miso_val;

    wire half_tick = (half_cnt == CNT_W'(SCK_HALF - 1));
    wire is_fall   = edge_cnt[0];
    wire accept    = cmd_valid && cmd_ready;
    wire frame_end = (state == H_END) && half_tick && edge_cnt[0];

    // Suspends are stalled at the command port until the resume spacing has passed.
    always_comb
    begin
        cmd_ready = (state == H_IDLE);
        if (cmd_opcode == OP_ERASE_SUSPEND && erase_gap != '0)
        begin
            cmd_ready = 1'b0;
        end
        if (cmd_opcode == OP_PROGRAM_SUSPEND && prog_gap != '0)
        begin
            cmd_ready = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state     <= H_IDLE;
            half_cnt  <= '0;
            edge_cnt  <= 5'h00;
            last_edge <= 5'h00;
            op_q      <= 8'h00;
        end
        else
        begin
            case (state)
                H_IDLE:
                begin
                    half_cnt <= '0;
                    edge_cnt <= 5'h00;
                    if (accept)
                    begin
                        state <= H_SHIFT;
                        op_q  <= cmd_opcode;
                        if (cmd_opcode == OP_READ_STATUS)
                        begin
                            last_edge <= 5'(2 * STATUS_FRAME_BITS - 1);
                        end
                        else
                        begin
                            last_edge <= 5'(2 * PLAIN_FRAME_BITS - 1);
                        end
                    end
                end
                H_SHIFT:
                begin
                    half_cnt <= half_tick ? '0 : half_cnt + CNT_W'(1);
                    if (half_tick)
                    begin
                        if (edge_cnt == last_edge)
                        begin
                            state    <= H_END;
                            edge_cnt <= 5'h00;
                        end
                        else
                        begin
                            edge_cnt <= edge_cnt + 5'h01;
                        end
                    end
                end
                H_END:
                begin
                    half_cnt <= half_tick ? '0 : half_cnt + CNT_W'(1);
                    if (half_tick)
                    begin
                        edge_cnt <= edge_cnt + 5'h01;
                        if (edge_cnt[0])
                        begin
                            state <= H_IDLE;
                        end
                    end
                end
                default:
                begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sck_q <= 1'b0;
        end
        else if (state == H_SHIFT && half_tick)
        begin
            sck_q <= !is_fall;
        end
    end

    // Chip select rises half a clock period after the last fall and stays high for another half.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cs_n_q <= 1'b1;
        end
        else if (accept)
        begin
            cs_n_q <= 1'b0;
        end
        else if (state == H_END && half_tick && !edge_cnt[0])
        begin
            cs_n_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx     <= 8'h00;
            mosi_q <= 1'b0;
        end
        else if (accept)
        begin
            tx     <= {cmd_opcode[6:0], 1'b0};
            mosi_q <= cmd_opcode[7];
        end
        else if (state == H_SHIFT && half_tick && is_fall)
        begin
            tx     <= {tx[6:0], 1'b0};
            mosi_q <= tx[7];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            m1 <= 1'b0;
            m2 <= 1'b0;
            m3 <= 1'b0;
            miso_val <= 1'b0;
        end
        else
        begin
            m1 <= lnk.miso;
            m2 <= m1;
            m3 <= m2;
            if (m2 == m3)
            begin
                miso_val <= m3;
            end
        end
    end

    // Data is taken at the fall that ends each bit, leaving the synchroniser a full link clock period.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx <= 8'h00;
        end
        else if (state == H_SHIFT && half_tick && is_fall && edge_cnt > 5'(2 * PLAIN_FRAME_BITS - 1))
        begin
            rx <= {rx[6:0], miso_val};
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            status_valid          <= 1'b0;
            status_byte           <= 8'h00;
            busy_in_progress_flag <= 1'b0;
        end
        else
        begin
            status_valid <= frame_end && op_q == OP_READ_STATUS;
            if (frame_end && op_q == OP_READ_STATUS)
            begin
                status_byte           <= rx;
                busy_in_progress_flag <= rx[STATUS_BUSY_BIT];
            end
        end
    end

    // Spacing is counted from the end of the resume frame, when the device has the opcode.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            erase_gap <= '0;
            prog_gap  <= '0;
        end
        else
        begin
            if (frame_end && op_q == OP_ERASE_RESUME)
            begin
                erase_gap <= CNT_W'(ERASE_RESUME_GAP);
            end
            else if (erase_gap != '0)
            begin
                erase_gap <= erase_gap - CNT_W'(1);
            end
            if (frame_end && op_q == OP_PROGRAM_RESUME)
            begin
                prog_gap <= CNT_W'(PROG_RESUME_GAP);
            end
            else if (prog_gap != '0)
            begin
                prog_gap <= prog_gap - CNT_W'(1);
            end
        end
    end

    // The host trusts its own suspends; a suspend the device ignored leaves these set until a resume.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            erase_held   <= 1'b0;
            program_held <= 1'b0;
            held_sector  <= '0;
        end
        else if (accept)
        begin
            if (cmd_opcode == OP_ERASE_SUSPEND)
            begin
                erase_held  <= 1'b1;
                held_sector <= erase_sector;
            end
            else if (cmd_opcode == OP_ERASE_RESUME)
            begin
                erase_held <= 1'b0;
            end
            else if (cmd_opcode == OP_PROGRAM_SUSPEND)
            begin
                program_held <= 1'b1;
            end
            else if (cmd_opcode == OP_PROGRAM_RESUME)
            begin
                program_held <= 1'b0;
            end
        end
    end

    assign erase_start_ok   = !erase_held && !program_held;
    assign program_start_ok = !program_held && !(erase_held && program_sector == held_sector);

    assign lnk.sck  = sck_q;
    assign lnk.cs_n = cs_n_q;
    assign lnk.mosi = mosi_q;
endmodule
`default_nettype wire

//--- flash_susp_pkg.sv
`default_nettype none
package flash_susp_pkg;
    localparam logic [7:0] OP_ERASE_SUSPEND   = 8'h75;
    localparam logic [7:0] OP_ERASE_RESUME    = 8'h7A;
    localparam logic [7:0] OP_PROGRAM_SUSPEND = 8'h85;
    localparam logic [7:0] OP_PROGRAM_RESUME  = 8'h8A;
    localparam logic [7:0] OP_READ_STATUS     = 8'h05;
    localparam int         STATUS_BUSY_BIT    = 0;

    localparam int CLK_PERIOD_PS = 4000;
    localparam int PS_PER_US     = 1000000;

    localparam int         SUSP_UNIT_US       = 8;
    localparam logic [4:0] ERASE_SUSP_COUNT   = 5'h04;
    localparam logic [4:0] PROGRAM_SUSP_COUNT = 5'h04;
    localparam int         ERASE_SUSP_MAX_US  = (int'(ERASE_SUSP_COUNT) + 1) * SUSP_UNIT_US;
    localparam int         PROGRAM_SUSP_MAX_US = (int'(PROGRAM_SUSP_COUNT) + 1) * SUSP_UNIT_US;
    localparam int         ERASE_SUSP_MAX_CYCLES   = ERASE_SUSP_MAX_US * PS_PER_US / CLK_PERIOD_PS;
    localparam int         PROGRAM_SUSP_MAX_CYCLES = PROGRAM_SUSP_MAX_US * PS_PER_US / CLK_PERIOD_PS;

    localparam int         RESUME_GAP_UNIT_US       = 64;
    localparam logic [3:0] ERASE_RESUME_GAP_COUNT   = 4'h1;
    localparam logic [3:0] PROGRAM_RESUME_GAP_COUNT = 4'h1;
    localparam int         ERASE_RESUME_GAP_US   = (int'(ERASE_RESUME_GAP_COUNT) + 1) * RESUME_GAP_UNIT_US;
    localparam int         PROGRAM_RESUME_GAP_US = (int'(PROGRAM_RESUME_GAP_COUNT) + 1) * RESUME_GAP_UNIT_US;
    localparam int         ERASE_RESUME_GAP_CYCLES =
        (ERASE_RESUME_GAP_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int         PROGRAM_RESUME_GAP_CYCLES =
        (PROGRAM_RESUME_GAP_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int CNT_W              = 16;
    localparam int PLAIN_FRAME_BITS   = 8;
    localparam int STATUS_FRAME_BITS  = 16;
    localparam int SCK_HALF_CYCLES    = 4;
    localparam int ERASE_WORK_CYCLES  = 2000;
    localparam int PROGRAM_WORK_CYCLES = 500;
    localparam int SECTOR_W           = 8;

    typedef enum logic [2:0]
    {
        ST_IDLE       = 3'b000,
        ST_ERASE      = 3'b001,
        ST_PROG       = 3'b010,
        ST_ERASE_STOP = 3'b011,
        ST_PROG_STOP  = 3'b100
    } dev_state_t;

    typedef enum logic [1:0]
    {
        H_IDLE  = 2'b00,
        H_SHIFT = 2'b01,
        H_END   = 2'b10
    } host_state_t;
endpackage
`default_nettype wire

//--- flash_suspend_resume_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_suspend_resume_control_checker
    import flash_susp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic       sck_q;
    logic [4:0] rises;
    logic [7:0] sh;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Rising edges are found from sampled values, so the count lags the wire by one clock.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sck_q <= 1'b0;
            rises <= 5'h00;
            sh    <= 8'h00;
        end
        else
        begin
            sck_q <= sck;
            rises <= cs_n ? 5'h00 : rises + 5'(sck && !sck_q);
            if (sck && !sck_q)
                sh <= {sh[6:0], mosi};
        end
    end
    property p_idle; cs_n |-> !sck; endproperty
    a_idle: assert property (p_idle) else $error("link clock not idle low");
    property p_oe_off; cs_n && $past(cs_n) |-> !miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("device drives outside frame");
    property p_miso_low; !miso_oe && !$past(miso_oe, 2) |-> !miso; endproperty
    a_miso_low: assert property (p_miso_low) else $error("data line not low when released");
    property p_half; $rose(sck) |-> sck[*4] ##1 !sck; endproperty
    a_half: assert property (p_half) else $error("link clock high time wrong");
    property p_mosi; sck |-> $stable(mosi); endproperty
    a_mosi: assert property (p_mosi) else $error("host data moved while clock high");
    property p_miso; miso_oe && sck |-> $stable(miso); endproperty
    a_miso: assert property (p_miso) else $error("device data moved while clock high");
    property p_frame; $fell(cs_n) |-> ##67 !cs_n ##1 (cs_n or (!cs_n ##64 cs_n)); endproperty
    a_frame: assert property (p_frame) else $error("frame length wrong");
    property p_bits; $rose(cs_n) |-> rises == 5'h08 || rises == 5'h10; endproperty
    a_bits: assert property (p_bits) else $error("frame bit count wrong");
    property p_status; $rose(miso_oe) |-> ##1 sh == OP_READ_STATUS; endproperty
    a_status: assert property (p_status) else $error("device answered a non-status opcode");
    c_plain: cover property ($rose(cs_n) && rises == 5'h08);
    c_long: cover property ($rose(cs_n) && rises == 5'h10);
    c_answer: cover property ($rose(miso_oe));
endmodule
`default_nettype wire

//--- flash_suspend_resume_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_suspend_resume_control_tb;
    import flash_susp_pkg::*;
    logic clk = 0, rst = 1, cmd_valid = 0, start_erase = 0, start_program = 0;
    logic [7:0] cmd_opcode = 8'h00, status_byte, esec = 8'h03, psec = 8'h03;
    logic cmd_ready, status_valid, hbusy, eheld, pheld, eok, pok, dbusy, esus, psus, op_done;
    int n_mismatch = 0, cmp_count = 0;
    flash_link_if lnk();
    flash_susp_device #(.ERASE_CYCLES(1000), .ERASE_SUSPEND_CYCLES(20),
        .PROG_SUSPEND_CYCLES(20)) i_flash_susp_device (.clk(clk), .rst(rst), .start_erase(start_erase),
        .start_program(start_program), .busy_in_progress_flag(dbusy), .erase_suspended(esus),
        .program_suspended(psus), .op_done(op_done), .lnk(lnk.device));
    flash_susp_host #(.ERASE_RESUME_GAP(50), .PROG_RESUME_GAP(50)) i_flash_susp_host (.clk(clk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_ready(cmd_ready), .status_valid(status_valid),
        .status_byte(status_byte), .busy_in_progress_flag(hbusy), .erase_sector(esec),
        .program_sector(psec), .erase_held(eheld), .program_held(pheld), .erase_start_ok(eok),
        .program_start_ok(pok), .lnk(lnk.host));
    flash_suspend_resume_control_checker i_chk (.clk(clk), .rst(rst), .sck(lnk.sck), .cs_n(lnk.cs_n),
        .mosi(lnk.mosi), .miso(lnk.miso), .miso_oe(lnk.miso_oe));
    always #2 clk = ~clk;
    task automatic report_and_stop();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_for(ref logic s, input int lim);
        int i;
        i = 0;
        while (s !== 1'b1)
        begin
            @(negedge clk);
            i++;
            if (i > lim)
            begin
                n_mismatch++;
                $display("[ERR] %0t: wait ran out", $time);
                report_and_stop();
            end
        end
    endtask
    // The request is raised at a falling edge and dropped only after the rising edge that took it.
    task automatic send(input logic [7:0] op);
        @(negedge clk);
        cmd_opcode = op;
        cmd_valid = 1'b1;
        wait_for(cmd_ready, 40000);
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        wait_for(cmd_ready, 500);
        // The status pulse stands in the cycle in which the port turns ready again.
        chk({7'h00, status_valid}, {7'h00, op == OP_READ_STATUS});
        // Leaves time for the opcode to cross into the device clock domain.
        repeat (8) @(negedge clk);
    endtask
    task automatic refuse(input logic [7:0] op);
        @(negedge clk);
        cmd_opcode = op;
        cmd_valid = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h00, cmd_ready}, 8'h00);
        cmd_valid = 1'b0;
    endtask
    task automatic status(input logic b);
        send(OP_READ_STATUS);
        chk(status_byte, {7'h00, b});
        chk({7'h00, hbusy}, {7'h00, b});
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk({cmd_ready, eok, pok, dbusy, esus, psus, eheld, pheld}, 8'hE0);
        status(1'b0);
        send(OP_PROGRAM_SUSPEND);
        chk({6'h00, dbusy, psus}, 8'h00);
        send(OP_PROGRAM_RESUME);
        chk({6'h00, dbusy, psus}, 8'h00);
        pulse(start_erase);
        status(1'b1);
        send(OP_ERASE_SUSPEND);
        wait_for(esus, 25);
        chk({5'h00, dbusy, eheld, eok}, 8'h02);
        chk({7'h00, pok}, 8'h00);
        psec = 8'h04;
        @(negedge clk);
        chk({7'h00, pok}, 8'h01);
        status(1'b0);
        send(OP_ERASE_RESUME);
        chk({5'h00, esus, dbusy, eheld}, 8'h02);
        refuse(OP_ERASE_SUSPEND);
        // A bound below a full erase shows that the resumed erase kept its progress.
        wait_for(op_done, 850);
        pulse(start_program);
        send(OP_PROGRAM_SUSPEND);
        wait_for(psus, 25);
        chk({5'h00, pheld, pok, dbusy}, 8'h04);
        send(OP_PROGRAM_RESUME);
        chk({6'h00, psus, dbusy}, 8'h01);
        refuse(OP_PROGRAM_SUSPEND);
        wait_for(op_done, 450);
        report_and_stop();
    end
endmodule
`default_nettype wire
